// >>> rtl/bios_shadow_pkg.sv
package bios_shadow_pkg;

  // ****************************************************************
  // Register map (byte offsets in configuration space)
  // ****************************************************************
  localparam logic [7:0] ATTR_D8_OFFSET = 8'h94;  // Segments 0D8000-0DFFFF
  localparam logic [7:0] ATTR_E0_OFFSET = 8'h95;  // Segments 0E0000-0E7FFF
  localparam logic [7:0] ATTR_RESET     = 8'h00;  // Both fields reset to 00
  localparam logic [7:0] ATTR_RW_MASK   = 8'h33;  // Bits 7:6 and 3:2 reserved

  // ****************************************************************
  // Field layout
  // ****************************************************************
  localparam int UPPER_ATTR_LSB = 4;              // upper_segment_attr, bits 5:4
  localparam int LOWER_ATTR_LSB = 0;              // lower_segment_attr, bits 1:0

  // ****************************************************************
  // Attribute encodings
  // ****************************************************************
  localparam logic [1:0] ATTR_LINK_ONLY  = 2'h0;  // Everything to downstream_link
  localparam logic [1:0] ATTR_READ_DRAM  = 2'h1;  // Reads DRAM, writes link
  localparam logic [1:0] ATTR_WRITE_DRAM = 2'h2;  // Writes DRAM, reads link
  localparam logic [1:0] ATTR_ALL_DRAM   = 2'h3;  // Normal memory

  // ****************************************************************
  // Governed segments, 16 KB each
  // ****************************************************************
  localparam int SEG_SIZE_BITS = 14;              // 16 KB granule
  localparam logic [31:0] SEG_D8_BASE = 32'h000D_8000;
  localparam logic [31:0] SEG_DC_BASE = 32'h000D_C000;
  localparam logic [31:0] SEG_E0_BASE = 32'h000E_0000;
  localparam logic [31:0] SEG_E4_BASE = 32'h000E_4000;

  // Segment index as produced by the segment decoder
  typedef enum logic [3:0] {
    SEG_D8 = 4'h1,
    SEG_DC = 4'h2,
    SEG_E0 = 4'h4,
    SEG_E4 = 4'h8
  } seg_onehot_t;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic       wr;      // Write strobe
    logic       rd;      // Read strobe
    logic [7:0] offset;  // Byte offset
    logic [7:0] wdata;   // Write data
  } cfg_req_t;

  typedef struct packed {
    logic        valid;     // Cycle present
    logic        write;     // 1 write, 0 read
    logic        dflt_dram; // Routing chosen elsewhere for ungoverned space
    logic [31:0] addr;      // Byte address
  } host_cyc_t;

  typedef struct packed {
    logic        valid;     // Routed cycle present
    logic        write;     // Direction of the cycle
    logic        to_dram;   // Serviced by DRAM
    logic        to_link;   // Forwarded on downstream_link
    logic        governed;  // Hit one of the four segments
    logic [1:0]  field;     // Attribute that decided it
    logic [31:0] addr;      // Address passed through
  } route_t;

endpackage

// >>> rtl/segment_decoder.sv
`timescale 1ns/100ps

// Combinational lookup of the governing segment and its attribute field
module segment_decoder (
  input  wire logic [31:0] addr_in,
  input  wire logic [7:0]  attr_d8_in,
  input  wire logic [7:0]  attr_e0_in,
  output logic             hit_out,
  output logic [3:0]       seg_out,
  output logic [1:0]       field_out
);

  // ****************************************************************
  // Segment match
  // ****************************************************************
  logic [31:0] granule;  // Address rounded down to 16 KB

  // Compare whole granules so the low bits never matter
  always_comb begin
    granule = {addr_in[31:bios_shadow_pkg::SEG_SIZE_BITS], {bios_shadow_pkg::SEG_SIZE_BITS{1'b0}}};
    seg_out = 4'h0;
    if (granule == bios_shadow_pkg::SEG_D8_BASE) begin
      seg_out = bios_shadow_pkg::SEG_D8;
    end else if (granule == bios_shadow_pkg::SEG_DC_BASE) begin
      seg_out = bios_shadow_pkg::SEG_DC;
    end else if (granule == bios_shadow_pkg::SEG_E0_BASE) begin
      seg_out = bios_shadow_pkg::SEG_E0;
    end else if (granule == bios_shadow_pkg::SEG_E4_BASE) begin
      seg_out = bios_shadow_pkg::SEG_E4;
    end
  end

  // ****************************************************************
  // Field selection
  // ****************************************************************
  // Pick the field that governs the matched segment
  always_comb begin
    hit_out   = (seg_out != 4'h0);
    field_out = bios_shadow_pkg::ATTR_LINK_ONLY;
    unique case (seg_out)
      bios_shadow_pkg::SEG_DC: begin
        field_out = attr_d8_in[bios_shadow_pkg::UPPER_ATTR_LSB +: 2]; // RULE1
      end
      bios_shadow_pkg::SEG_D8: begin
        field_out = attr_d8_in[bios_shadow_pkg::LOWER_ATTR_LSB +: 2]; // RULE2
      end
      bios_shadow_pkg::SEG_E4: begin
        field_out = attr_e0_in[bios_shadow_pkg::UPPER_ATTR_LSB +: 2]; // RULE3
      end
      bios_shadow_pkg::SEG_E0: begin
        field_out = attr_e0_in[bios_shadow_pkg::LOWER_ATTR_LSB +: 2]; // RULE4
      end
      default: begin
        // No segment: field unused
        field_out = bios_shadow_pkg::ATTR_LINK_ONLY;
      end
    endcase
  end

endmodule

// >>> rtl/bios_shadow_attribute_map.sv
`timescale 1ns/100ps

// What this block does
// [RULE1] Segment DC000-DFFFF follows first register bits 5:4
// [RULE2] Segment D8000-DBFFF follows first register bits 1:0
// [RULE3] Segment E4000-E7FFF follows second register bits 5:4
// [RULE4] Segment E0000-E3FFF follows second register bits 1:0
// [RULE5] Field 00 sends everything to the link
// [RULE6] Field 01 reads DRAM, writes link
// [RULE7] Field 10 writes DRAM, reads link
// [RULE8] Field 11 sends everything to DRAM
// [RULE9] Two 8-bit RW registers, fields reset 00
// [RULE10] Reserved bits read zero; other space untouched
module bios_shadow_attribute_map (
  input  wire logic                       clk_sys_in,
  input  wire logic                       reset_in,
  input  wire bios_shadow_pkg::cfg_req_t  cfg_req_in,
  input  wire bios_shadow_pkg::host_cyc_t host_cyc_in,
  output logic [7:0]                      cfg_rdata_out,
  output logic                            cfg_rvalid_out,
  output logic                            cfg_claim_out,
  output bios_shadow_pkg::route_t         route_out
);

  // ****************************************************************
  // Decoding helpers
  // ****************************************************************
  // Pure functions, shared by the logic and the checks;
  // the key checks still compare raw register bits

  // Does this attribute send this direction to DRAM
  function automatic logic dram_for(input logic [1:0] field, input logic write);
    logic r;
    r = 1'b0;
    unique case (field)
      bios_shadow_pkg::ATTR_LINK_ONLY:  r = 1'b0;   // RULE5
      bios_shadow_pkg::ATTR_READ_DRAM:  r = !write; // RULE6
      bios_shadow_pkg::ATTR_WRITE_DRAM: r = write;  // RULE7
      bios_shadow_pkg::ATTR_ALL_DRAM:   r = 1'b1;   // RULE8
    endcase
    return r;
  endfunction

  // Does an offset belong to this block
  function automatic logic is_ours(input logic [7:0] offset);
    return (offset == bios_shadow_pkg::ATTR_D8_OFFSET) || (offset == bios_shadow_pkg::ATTR_E0_OFFSET);
  endfunction

  // ****************************************************************
  // Attribute registers
  // ****************************************************************
  logic [7:0] attr_d8_r;    // bios_segment_attr_d8
  logic [7:0] attr_e0_r;    // bios_segment_attr_e0
  logic [7:0] wdata_masked; // Write data with reserved bits dropped

  // Reserved bits never store, so they always read back zero
  assign wdata_masked = cfg_req_in.wdata & bios_shadow_pkg::ATTR_RW_MASK; // RULE10

  // Byte writes from configuration space
  // A host cycle on the write edge still sees the old map
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      // Every segment starts closed to DRAM
      attr_d8_r <= bios_shadow_pkg::ATTR_RESET; // RULE9
      attr_e0_r <= bios_shadow_pkg::ATTR_RESET; // RULE9
    end else if (cfg_req_in.wr) begin
      // Only one offset can match, so no priority is needed
      if (cfg_req_in.offset == bios_shadow_pkg::ATTR_D8_OFFSET) begin
        attr_d8_r <= wdata_masked; // RULE9
      end
      if (cfg_req_in.offset == bios_shadow_pkg::ATTR_E0_OFFSET) begin
        attr_e0_r <= wdata_masked; // RULE9
      end
    end
  end

  // ****************************************************************
  // Configuration read port
  // ****************************************************************

  // Read data one cycle after the strobe; unmapped offsets read zero
  // Read data holds until the next read strobe
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      // Nothing claimed or answered in reset
      cfg_rdata_out  <= 8'h00;
      cfg_rvalid_out <= 1'b0;
      cfg_claim_out  <= 1'b0;
    end else begin
      // Every read is answered, even a foreign offset
      cfg_rvalid_out <= cfg_req_in.rd;
      cfg_claim_out  <= (cfg_req_in.rd || cfg_req_in.wr) && is_ours(cfg_req_in.offset);
      if (cfg_req_in.rd) begin
        if (cfg_req_in.offset == bios_shadow_pkg::ATTR_D8_OFFSET) begin
          cfg_rdata_out <= attr_d8_r & bios_shadow_pkg::ATTR_RW_MASK; // RULE10
        end else if (cfg_req_in.offset == bios_shadow_pkg::ATTR_E0_OFFSET) begin
          cfg_rdata_out <= attr_e0_r & bios_shadow_pkg::ATTR_RW_MASK; // RULE10
        end else begin
          cfg_rdata_out <= 8'h00; // Not ours
        end
      end
    end
  end

  // ****************************************************************
  // Segment lookup
  // ****************************************************************
  // Purely combinational; registered in the steering stage
  logic       seg_hit;   // Cycle falls in a governed segment
  logic [3:0] seg_sel;   // One-hot segment
  logic [1:0] seg_field; // Governing attribute field

  segment_decoder u_segment_decoder (
    .addr_in    (host_cyc_in.addr),
    .attr_d8_in (attr_d8_r),
    .attr_e0_in (attr_e0_r),
    .hit_out    (seg_hit),
    .seg_out    (seg_sel),
    .field_out  (seg_field)
  );

  // ****************************************************************
  // Cycle steering
  // ****************************************************************
  logic steer_dram; // DRAM chosen for the incoming cycle

  // Governed cycles follow the field; others keep the upstream choice
  always_comb begin
    if (seg_hit) begin
      steer_dram = dram_for(seg_field, host_cyc_in.write); // RULE5 RULE6 RULE7 RULE8
    end else begin
      steer_dram = host_cyc_in.dflt_dram; // RULE10
    end
  end

  // One register stage; exactly one target per valid cycle
  // Costs a cycle of latency, buys flop-driven targets
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      route_out <= '0;
    end else begin
      route_out.valid    <= host_cyc_in.valid;
      route_out.write    <= host_cyc_in.write;
      route_out.addr     <= host_cyc_in.addr;
      route_out.governed <= host_cyc_in.valid && seg_hit;
      route_out.field    <= seg_hit ? seg_field : bios_shadow_pkg::ATTR_LINK_ONLY;
      // Targets stay low on idle cycles so nothing fires spuriously
      route_out.to_dram  <= host_cyc_in.valid && steer_dram;
      route_out.to_link  <= host_cyc_in.valid && !steer_dram;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  // One clock for all checks; reset masks them
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);

  // Helper: segment of the incoming cycle by plain range test
  // Bounds written by hand, not taken from the decoder,
  // so a wrong base in either place shows
  logic in_dc;
  logic in_d8;
  logic in_e4;
  logic in_e0;
  assign in_dc = (host_cyc_in.addr >= 32'h000D_C000) && (host_cyc_in.addr <= 32'h000D_FFFF);
  assign in_d8 = (host_cyc_in.addr >= 32'h000D_8000) && (host_cyc_in.addr <= 32'h000D_BFFF);
  assign in_e4 = (host_cyc_in.addr >= 32'h000E_4000) && (host_cyc_in.addr <= 32'h000E_7FFF);
  assign in_e0 = (host_cyc_in.addr >= 32'h000E_0000) && (host_cyc_in.addr <= 32'h000E_3FFF);

  // Helper: a strobe aimed at one of our two offsets
  logic cfg_own_access;
  assign cfg_own_access = (cfg_req_in.rd || cfg_req_in.wr) &&
                          (cfg_req_in.offset == 8'h94 || cfg_req_in.offset == 8'h95);

  // ****************************************************************
  // Steering checks
  // ****************************************************************
  // Each segment picks its own field, not its neighbour's
  a_dc_upper_field: assert property ( // RULE1
    host_cyc_in.valid && in_dc |=> route_out.governed && route_out.field == $past(attr_d8_r[5:4]) &&
      route_out.to_dram == dram_for($past(attr_d8_r[5:4]), $past(host_cyc_in.write)))
    else $error("DC segment not steered by first register bits 5:4");

  a_d8_lower_field: assert property ( // RULE2
    host_cyc_in.valid && in_d8 |=> route_out.governed &&
      route_out.field == $past(attr_d8_r[1:0]))
    else $error("D8 segment not steered by first register bits 1:0");

  a_e4_upper_field: assert property ( // RULE3
    host_cyc_in.valid && in_e4 |=> route_out.governed &&
      route_out.field == $past(attr_e0_r[5:4]))
    else $error("E4 segment not steered by second register bits 5:4");

  // Lower field of the second register
  a_e0_lower_field: assert property ( // RULE4
    host_cyc_in.valid && in_e0 |=> route_out.governed && route_out.field == $past(attr_e0_r[1:0]) &&
      route_out.to_dram == dram_for($past(attr_e0_r[1:0]), $past(host_cyc_in.write)))
    else $error("E0 segment not steered by second register bits 1:0");

  // Mode checks use the field applied, for any segment
  a_link_only_mode: assert property ( // RULE5
    route_out.governed && route_out.field == 2'h0 |-> route_out.to_link && !route_out.to_dram)
    else $error("Field 00 reached DRAM");

  a_read_dram_mode: assert property ( // RULE6
    route_out.governed && route_out.field == 2'h1 |-> route_out.to_dram == !route_out.write)
    else $error("Field 01 routed wrongly");

  a_write_dram_mode: assert property ( // RULE7
    route_out.governed && route_out.field == 2'h2 |-> route_out.to_dram == route_out.write)
    else $error("Field 10 routed wrongly");

  a_all_dram_mode: assert property ( // RULE8
    route_out.governed && route_out.field == 2'h3 |-> route_out.to_dram && !route_out.to_link)
    else $error("Field 11 did not reach DRAM");

  // Idle slots carry no target and are not marked governed
  a_idle_no_target: assert property (
    !route_out.valid |-> !route_out.to_dram && !route_out.to_link && !route_out.governed)
    else $error("Idle slot carried a target");

  // Ungoverned cycles report the neutral code
  a_ungoverned_field_zero: assert property (
    !route_out.governed |-> route_out.field == 2'h0)
    else $error("Field on ungoverned cycle");

  // Address and direction pass one cycle later
  a_cycle_pass_through: assert property (
    host_cyc_in.valid |=> route_out.valid && route_out.addr == $past(host_cyc_in.addr) &&
      route_out.write == $past(host_cyc_in.write))
    else $error("Cycle address or direction altered");

  // ****************************************************************
  // Register checks
  // ****************************************************************
  // Reset leaves both maps closed to DRAM
  a_reset_fields_zero: assert property ( // RULE9
    $fell(reset_in) |-> attr_d8_r == 8'h00 && attr_e0_r == 8'h00)
    else $error("Attribute registers not zero after reset");

  // Write then read on the next edge
  a_write_read_back: assert property ( // RULE9
    cfg_req_in.wr && cfg_req_in.offset == 8'h94 ##1 cfg_req_in.rd && cfg_req_in.offset == 8'h94 &&
      !cfg_req_in.wr |=> cfg_rdata_out == ($past(cfg_req_in.wdata, 2) & 8'h33))
    else $error("Written value did not read back");

  a_reserved_read_zero: assert property ( // RULE10
    cfg_rvalid_out |-> cfg_rdata_out[7:6] == 2'h0 && cfg_rdata_out[3:2] == 2'h0)
    else $error("Reserved bits read nonzero");

  // Outside the segments the upstream choice stands
  a_ungoverned_pass: assert property ( // RULE10
    host_cyc_in.valid && !(in_dc || in_d8 || in_e4 || in_e0) |=>
      !route_out.governed && route_out.to_dram == $past(host_cyc_in.dflt_dram))
    else $error("Ungoverned cycle was altered");

  // Never both targets, never none
  a_one_target: assert property (
    route_out.valid |-> route_out.to_dram != route_out.to_link)
    else $error("Cycle not sent to exactly one target");

  // Every read answered one cycle later
  a_read_answer_timing: assert property ( // RULE9
    cfg_rvalid_out == $past(cfg_req_in.rd))
    else $error("Read answer mistimed");

  // Only our two offsets are claimed
  a_claim_own_offset: assert property ( // RULE9
    cfg_claim_out == $past(cfg_own_access))
    else $error("Claim does not follow offset");

  // Foreign writes leave both maps alone
  a_foreign_write_ignored: assert property ( // RULE9
    cfg_req_in.wr && !cfg_own_access |=> $stable(attr_d8_r) && $stable(attr_e0_r))
    else $error("Foreign write changed a map");

  // Reserved bits are never stored
  a_reserved_stored_zero: assert property ( // RULE10
    (attr_d8_r & 8'hCC) == 8'h00 && (attr_e0_r & 8'hCC) == 8'h00)
    else $error("Reserved bit stored");

  // Read paired with write sees the old value
  a_read_old_value: assert property ( // RULE9
    cfg_req_in.rd && cfg_req_in.wr && cfg_req_in.offset == 8'h95 |=> cfg_rdata_out == $past(attr_e0_r))
    else $error("Paired read saw new value");

  // Read data stands until the next read
  a_read_data_holds: assert property ( // RULE9
    !cfg_req_in.rd |=> $stable(cfg_rdata_out))
    else $error("Read data changed without a read");

  // ****************************************************************
  // Coverage
  // ****************************************************************
  // Main scenarios the bench should reach
  c_foreign_write: cover property (cfg_req_in.wr && !cfg_own_access);
  c_shadow_write: cover property (route_out.governed && route_out.field == 2'h2 && route_out.write);
  c_shadow_read: cover property (route_out.governed && route_out.field == 2'h1 && !route_out.write);
  c_attr_update: cover property (cfg_req_in.wr && is_ours(cfg_req_in.offset) ##1 host_cyc_in.valid && seg_hit);
  c_normal_dram: cover property (route_out.governed && route_out.field == 2'h3);

endmodule

// >>> bench/route_sink_model.sv
`timescale 1ns/100ps

// ****************************************************************
// Far side: DRAM controller and downstream_link sink
// ****************************************************************
module route_sink_model (
  input  wire logic                     clk_sys_in,
  input  wire logic                     reset_in,
  input  wire bios_shadow_pkg::route_t  route_in,
  output int                            dram_cnt_out,
  output int                            link_cnt_out,
  output int                            bad_cnt_out
);
  // Each side takes the cycles handed to it; a cycle with two owners or none is counted as bad
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      dram_cnt_out <= 0;
      link_cnt_out <= 0;
      bad_cnt_out  <= 0;
    end else if (route_in.valid === 1'b1) begin
      // DRAM accepts what it is given
      if (route_in.to_dram === 1'b1) begin
        dram_cnt_out <= dram_cnt_out + 1;
      end
      // The link accepts what it is given
      if (route_in.to_link === 1'b1) begin
        link_cnt_out <= link_cnt_out + 1;
      end
      // Exactly one owner per cycle, else the host would hang or see two answers
      if ((route_in.to_dram ^ route_in.to_link) !== 1'b1) begin
        bad_cnt_out <= bad_cnt_out + 1;
      end
    end
  end
endmodule

// >>> bench/bios_shadow_attribute_map_bench.sv
`timescale 1ns/100ps

module bios_shadow_attribute_map_bench;
  // ****************************************************************
  // Signals
  // ****************************************************************
  logic                       clk_sys_in  = 1'b0;     // 100 MHz
  logic                       reset_in    = 1'b1;     // Synchronous, high
  bios_shadow_pkg::cfg_req_t  cfg_req_in  = '0;       // Config strobes
  bios_shadow_pkg::host_cyc_t host_cyc_in = '0;       // Host cycles
  logic [7:0]                 cfg_rdata_out;          // Read data
  logic                       cfg_rvalid_out;         // Read answer
  logic                       cfg_claim_out;          // Offset claimed
  bios_shadow_pkg::route_t    route_out;              // Steering result
  int                         dram_cnt;               // Far-side tallies
  int                         link_cnt;
  int                         bad_cnt;
  int                         error_cnt  = 0;         // Mismatches
  int                         n_compared = 0;         // Comparisons

  // Clock, 10 ns period
  initial begin
    forever #5 clk_sys_in = ~clk_sys_in;
  end

  bios_shadow_attribute_map u_dut (
    .clk_sys_in     (clk_sys_in),
    .reset_in       (reset_in),
    .cfg_req_in     (cfg_req_in),
    .host_cyc_in    (host_cyc_in),
    .cfg_rdata_out  (cfg_rdata_out),
    .cfg_rvalid_out (cfg_rvalid_out),
    .cfg_claim_out  (cfg_claim_out),
    .route_out      (route_out)
  );

  route_sink_model u_sink (
    .clk_sys_in   (clk_sys_in),
    .reset_in     (reset_in),
    .route_in     (route_out),
    .dram_cnt_out (dram_cnt),
    .link_cnt_out (link_cnt),
    .bad_cnt_out  (bad_cnt)
  );

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  // One comparison, counted; mismatch reported at once
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  // Verdict and end of run
  task automatic stop_test();
    $display("Counts: compared=%0d mismatches=%0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Config access; answer is looked at in the one cycle it stands
  task automatic cfg_cycle(input logic wr, input logic rd, input logic [7:0] off, input logic [7:0] wd,
                           input logic [7:0] exp_rd, input logic exp_claim);
    @(posedge clk_sys_in);
    cfg_req_in <= '{wr: wr, rd: rd, offset: off, wdata: wd};
    @(posedge clk_sys_in);
    cfg_req_in <= '0;
    #1;
    check({62'h0, cfg_rvalid_out, cfg_claim_out}, {62'h0, rd, exp_claim});
    if (rd) begin
      check({56'h0, cfg_rdata_out}, {56'h0, exp_rd});
    end
  endtask

  // Host cycle and its steering one cycle later
  task automatic host_cycle(input logic wr, input logic dflt, input logic [31:0] addr,
                            input logic gov, input logic [1:0] fld, input logic dram);
    bios_shadow_pkg::route_t exp_r;
    exp_r = '{valid: 1'b1, write: wr, to_dram: dram, to_link: ~dram, governed: gov, field: fld, addr: addr};
    @(posedge clk_sys_in);
    host_cyc_in <= '{valid: 1'b1, write: wr, dflt_dram: dflt, addr: addr};
    @(posedge clk_sys_in);
    host_cyc_in <= '0;
    #1;
    check({25'h0, route_out}, {25'h0, exp_r});
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  // Reset values, reserved bits, unmapped offset, read-with-write
  task automatic test_registers();
    cfg_cycle(1'b0, 1'b1, bios_shadow_pkg::ATTR_D8_OFFSET, 8'h00, 8'h00, 1'b1);
    cfg_cycle(1'b0, 1'b1, bios_shadow_pkg::ATTR_E0_OFFSET, 8'h00, 8'h00, 1'b1);
    host_cycle(1'b0, 1'b1, 32'h000D_C000, 1'b1, 2'h0, 1'b0);
    cfg_cycle(1'b1, 1'b0, bios_shadow_pkg::ATTR_D8_OFFSET, 8'hFF, 8'h00, 1'b1);
    cfg_cycle(1'b0, 1'b1, bios_shadow_pkg::ATTR_D8_OFFSET, 8'h00, 8'h33, 1'b1);
    // Write then read on the very next edge, no idle slot
    @(posedge clk_sys_in);
    cfg_req_in <= '{wr: 1'b1, rd: 1'b0, offset: bios_shadow_pkg::ATTR_D8_OFFSET, wdata: 8'hE5};
    @(posedge clk_sys_in);
    cfg_req_in <= '{wr: 1'b0, rd: 1'b1, offset: bios_shadow_pkg::ATTR_D8_OFFSET, wdata: 8'h00};
    @(posedge clk_sys_in);
    cfg_req_in <= '0;
    #1;
    check({55'h0, cfg_rvalid_out, cfg_rdata_out}, {55'h0, 1'b1, 8'h21});
    cfg_cycle(1'b1, 1'b1, bios_shadow_pkg::ATTR_E0_OFFSET, 8'hCE, 8'h00, 1'b1);
    cfg_cycle(1'b0, 1'b1, bios_shadow_pkg::ATTR_E0_OFFSET, 8'h00, 8'h02, 1'b1);
    cfg_cycle(1'b1, 1'b0, 8'h96, 8'hFF, 8'h00, 1'b0);
    cfg_cycle(1'b0, 1'b1, 8'h96, 8'h00, 8'h00, 1'b0);
    $display("test_registers done");
  endtask

  // Every encoding on every segment, a read at the first byte and a write at the last
  task automatic test_steering();
    logic [31:0] base;
    logic [7:0]  off;
    logic [7:0]  tgt;
    logic [7:0]  oth;
    logic [1:0]  inv;
    int          lsb;
    for (int s = 0; s < 4; s++) begin
      for (int v = 0; v < 4; v++) begin
        case (s)
          0: begin base = bios_shadow_pkg::SEG_D8_BASE; off = 8'h94; lsb = bios_shadow_pkg::LOWER_ATTR_LSB; end
          1: begin base = bios_shadow_pkg::SEG_DC_BASE; off = 8'h94; lsb = bios_shadow_pkg::UPPER_ATTR_LSB; end
          2: begin base = bios_shadow_pkg::SEG_E0_BASE; off = 8'h95; lsb = bios_shadow_pkg::LOWER_ATTR_LSB; end
          default: begin base = bios_shadow_pkg::SEG_E4_BASE; off = 8'h95; lsb = bios_shadow_pkg::UPPER_ATTR_LSB; end
        endcase
        // Neighbour field and other register hold the opposite code, so a wrong pick shows
        inv = ~v[1:0];
        tgt = (8'(v) << lsb) | (8'(inv) << (4 - lsb));
        oth = {2'h0, inv, 2'h0, inv};
        cfg_cycle(1'b1, 1'b0, off, tgt, 8'h00, 1'b1);
        cfg_cycle(1'b1, 1'b0, off ^ 8'h01, oth, 8'h00, 1'b1);
        host_cycle(1'b0, ~v[0], base, 1'b1, v[1:0], v[0]);
        host_cycle(1'b1, ~v[1], base + 32'h0000_3FFF, 1'b1, v[1:0], v[1]);
      end
    end
    $display("test_steering done");
  endtask

  // Addresses just outside the governed space, and an alias of D8000 with bit 28 set, follow the default route
  task automatic test_outside();
    cfg_cycle(1'b1, 1'b0, 8'h94, 8'h00, 8'h00, 1'b1);
    cfg_cycle(1'b1, 1'b0, 8'h95, 8'h00, 8'h00, 1'b1);
    host_cycle(1'b0, 1'b1, 32'h000D_7FFF, 1'b0, 2'h0, 1'b1);
    host_cycle(1'b1, 1'b0, 32'h000E_8000, 1'b0, 2'h0, 1'b0);
    host_cycle(1'b0, 1'b1, 32'h100D_8000, 1'b0, 2'h0, 1'b1);
    // Let the far side take the last cycle first
    @(posedge clk_sys_in);
    #1;
    check(64'(bad_cnt), 64'h0);
    check(64'(dram_cnt), 64'h12);
    check(64'(link_cnt), 64'h12);
    $display("test_outside done");
  endtask

  // ****************************************************************
  // Main sequence and watchdog
  // ****************************************************************
  initial begin
    repeat (6) @(posedge clk_sys_in);
    reset_in <= 1'b0;
    test_registers();
    test_steering();
    test_outside();
    stop_test();
  end

  // Whole run needs under two hundred cycles; allow ample margin
  initial begin
    #200000;
    error_cnt++;
    stop_test();
  end
endmodule
